/* nidl_pkg.sv */
/*
  Constants for the node identity, line pulse and diagnostic block.
  Assumes a 100 MHz system clock; all times are converted here.
*/
`default_nettype none
package nidl_pkg;
  // System clock period in ns
  localparam int unsigned CLK_PERIOD_NS  = 10;
  // Line pulse width in ns and in cycles (least time, round up)
  localparam int unsigned PULSE_NS       = 100;
  localparam int unsigned PULSE_CYC      = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Bit cell in ns and cycles
  localparam int unsigned CELL_NS        = 400;
  localparam int unsigned CELL_CYC       = CELL_NS / CLK_PERIOD_NS;
  // Receive tolerance in ns and cycles
  localparam int unsigned RX_TOL_NS      = 100;
  localparam int unsigned RX_TOL_CYC     = RX_TOL_NS / CLK_PERIOD_NS;
  // Transmit LED on time in us, cycles
  localparam int unsigned TX_LED_US      = 726;
  localparam int unsigned TX_LED_CYC     = TX_LED_US * 1000 / CLK_PERIOD_NS;
  // Bus LED on time in ms, cycles
  localparam int unsigned BUS_LED_MS     = 400;
  localparam int unsigned BUS_LED_CYC    = BUS_LED_MS * 100000;
  // Identity width and reserved zero identity
  localparam int unsigned ID_W           = 8;
  localparam logic [7:0]  ID_ZERO        = 8'h00;
  localparam logic [7:0]  ID_BROADCAST   = 8'h00;
  // Counter widths
  localparam int unsigned CNT_W          = 26;
  // Transmit phases
  typedef enum logic [1:0] {
    NIDL_TX_IDLE = 2'b00,
    NIDL_TX_PA   = 2'b01,
    NIDL_TX_PB   = 2'b10,
    NIDL_TX_REST = 2'b11
  } nidl_tx_t;
endpackage
`default_nettype wire

/* nidl_oneshot.sv */
/*
  Retriggerable one-shot driving an active-low LED.
  Assumes a synchronous trigger pulse in the clk domain.
*/
`timescale 1ns/100ps
`default_nettype none
module nidl_oneshot
  import nidl_pkg::*;
#(
  parameter int unsigned LEN = 16
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Trigger and LED
  input  wire logic trig,
  output var  logic led_n_ff
);
  logic [CNT_W-1:0] cnt_ff;      // Remaining on time
  logic [CNT_W-1:0] nxt_cnt;     // Next count
  wire              running = (cnt_ff != '0);

  // Reload on each trigger, otherwise count down
  assign nxt_cnt = trig ? CNT_W'(LEN) : (running ? cnt_ff - CNT_W'(1) : cnt_ff);

  ////////////////////////////////////////////////////////////////////////
  // Counter and LED register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_ff   <= '0;
      led_n_ff <= 1'b1;
    end else begin
      cnt_ff   <= nxt_cnt;
      led_n_ff <= (nxt_cnt == '0);
    end
  end
endmodule
`default_nettype wire

/* nidl_top.sv */
/*
  Node identity loading, line pulse transmit and receive, diagnostic flags
  and activity LEDs of a token-passing network controller.
  Assumes synchronous inputs; the protocol sequencer is outside and uses
  the run enable, token and reconfiguration event inputs given here.
*/
// Summary of operation
// - Reset samples switch identity into register
// - Host reads identity register at any time
// - Destination identity zero means broadcast
// - Zero switch identity holds node in reset
// - Nonzero host write releases held node
// - One bit gives two 100 ns low pulses
// - Receive pulses become NRZ, 400 ns cells
// - Self rebuild flag marks own reconfiguration
// - Rebuild flag raises processor interrupt
// - NRZ rising edge sets receive activity flag
// - Foreign token sets token seen flag
// - Transmit disable blocks transmit, keeps flags
// - Transmit LED one-shot, 726 us, retriggerable
// - Host access lights bus LED 400 ms
`timescale 1ns/100ps
`default_nettype none
module nidl_top
  import nidl_pkg::*;
#(
  parameter int unsigned TX_LED_LEN  = TX_LED_CYC,
  parameter int unsigned BUS_LED_LEN = BUS_LED_CYC
) (
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            rst_n,
  // Identity switches and host identity access
  input  wire logic [ID_W-1:0] id_switch,
  input  wire logic            id_wr,
  input  wire logic [ID_W-1:0] id_wdata,
  output var  logic [ID_W-1:0] node_id_ff,
  output var  logic            run_enable_ff,
  // Address match for received frames
  input  wire logic            dest_valid,
  input  wire logic [ID_W-1:0] dest_id,
  output var  logic            frame_for_us_ff,
  output var  logic            frame_broadcast_ff,
  // Transmit bit stream from sequencer
  input  wire logic            tx_bit_valid,
  input  wire logic            tx_bit,
  output var  logic            tx_bit_ready_ff,
  input  wire logic            transmit_disable_bit,
  output var  logic            line_pulse_a_n,
  output var  logic            line_pulse_b_n,
  // Receive path
  input  wire logic            line_receive_input,
  output var  logic            rx_nrz_ff,
  output var  logic            rx_bit_strobe_ff,
  // Protocol events and diagnostic status
  input  wire logic            token_seen_evt,
  input  wire logic            token_own_evt,
  input  wire logic            rebuild_done_evt,
  input  wire logic            rebuild_by_us,
  input  wire logic            diag_read,
  input  wire logic            status_read,
  output var  logic            rx_activity_flag,
  output var  logic            token_seen_flag,
  output var  logic            self_rebuild_flag,
  output var  logic            topology_rebuild_flag,
  output var  logic            irq_ff,
  // Host access and LEDs
  input  wire logic            host_access,
  output var  logic            transmit_led_n,
  output var  logic            bus_access_led_n
);

  ////////////////////////////////////////////////////////////////////////
  // Identity register
  logic start_ff;                          // High in first cycle after reset
  wire  id_write_ok = id_wr && (id_wdata != ID_ZERO);

  // Capture switches at reset release, host may overwrite later
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      start_ff      <= 1'b1;
      node_id_ff    <= ID_ZERO;
      run_enable_ff <= 1'b0;
    end else begin
      start_ff <= 1'b0;
      if (start_ff) begin
        node_id_ff    <= id_switch;
        run_enable_ff <= (id_switch != ID_ZERO);
      end else if (id_write_ok) begin
        node_id_ff    <= id_wdata;
        run_enable_ff <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Destination decode
  wire dest_bcast = (dest_id == ID_BROADCAST);
  wire dest_mine  = (dest_id == node_id_ff);

  // Flag broadcast and own frames for the sequencer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      frame_for_us_ff    <= 1'b0;
      frame_broadcast_ff <= 1'b0;
    end else begin
      frame_broadcast_ff <= dest_valid && dest_bcast;
      frame_for_us_ff    <= dest_valid && (dest_bcast || dest_mine);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmit pulse generator
  nidl_tx_t       tx_st_ff;                // Phase of the current cell
  logic [5:0]     tx_cnt_ff;               // Cycles left in phase
  logic           tx_one_ff;               // Current bit is a one
  wire            tx_allow   = run_enable_ff && !transmit_disable_bit;
  wire            tx_take    = tx_allow && tx_bit_valid && (tx_st_ff == NIDL_TX_IDLE);
  wire            tx_cnt_end = (tx_cnt_ff == 6'h00);
  wire            tx_send    = tx_take && tx_bit;

  // Each cell: pulse A, pulse B, then rest to fill 400 ns
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_st_ff        <= NIDL_TX_IDLE;
      tx_cnt_ff       <= 6'h00;
      tx_one_ff       <= 1'b0;
      line_pulse_a_n  <= 1'b1;
      line_pulse_b_n  <= 1'b1;
      tx_bit_ready_ff <= 1'b0;
    end else begin
      tx_bit_ready_ff <= 1'b0;
      case (tx_st_ff)
        NIDL_TX_IDLE: begin
          if (tx_take) begin
            tx_st_ff        <= NIDL_TX_PA;
            tx_one_ff       <= tx_bit;
            tx_cnt_ff       <= 6'(PULSE_CYC - 1);
            line_pulse_a_n  <= !tx_bit;
            tx_bit_ready_ff <= 1'b1;
          end
        end
        NIDL_TX_PA: begin
          if (tx_cnt_end) begin
            tx_st_ff       <= NIDL_TX_PB;
            tx_cnt_ff      <= 6'(PULSE_CYC - 1);
            line_pulse_a_n <= 1'b1;
            line_pulse_b_n <= !tx_one_ff;
          end else begin
            tx_cnt_ff <= tx_cnt_ff - 6'h01;
          end
        end
        NIDL_TX_PB: begin
          if (tx_cnt_end) begin
            tx_st_ff       <= NIDL_TX_REST;
            // Idle take and rest exit each cost a cycle, so a held bit stream keeps 400 ns cells
            tx_cnt_ff      <= 6'(CELL_CYC - 2 * PULSE_CYC - 2);
            line_pulse_b_n <= 1'b1;
          end else begin
            tx_cnt_ff <= tx_cnt_ff - 6'h01;
          end
        end
        NIDL_TX_REST: begin
          if (tx_cnt_end) begin
            tx_st_ff <= NIDL_TX_IDLE;
          end else begin
            tx_cnt_ff <= tx_cnt_ff - 6'h01;
          end
        end
        default: tx_st_ff <= NIDL_TX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive pulse to NRZ conversion
  logic       rx_prev_ff;                  // Previous line sample
  logic       rx_hit_ff;                   // Pulse seen in this cell
  logic [5:0] rx_cnt_ff;                   // Position within cell
  logic       rx_sync_ff;                  // Cell timing locked
  wire        rx_rise    = line_receive_input && !rx_prev_ff;
  wire        rx_cell_end = (rx_cnt_ff == 6'(CELL_CYC - 1));
  wire        rx_nrz_rise = rx_cell_end && rx_hit_ff && !rx_nrz_ff;

  // Cells centred on the first pulse; a later pulse from tolerance before centre to cell end marks the cell
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_prev_ff       <= 1'b0;
      rx_hit_ff        <= 1'b0;
      rx_cnt_ff        <= 6'h00;
      rx_sync_ff       <= 1'b0;
      rx_nrz_ff        <= 1'b0;
      rx_bit_strobe_ff <= 1'b0;
    end else begin
      rx_prev_ff       <= line_receive_input;
      rx_bit_strobe_ff <= rx_sync_ff && rx_cell_end;
      if (rx_rise && !rx_sync_ff) begin
        rx_sync_ff <= 1'b1;
        rx_hit_ff  <= 1'b1;
        rx_cnt_ff  <= 6'(CELL_CYC / 2);
      end else if (rx_cell_end) begin
        rx_nrz_ff <= rx_hit_ff;
        rx_hit_ff <= 1'b0;
        rx_cnt_ff <= 6'h00;
        if (!rx_hit_ff) begin
          rx_sync_ff <= 1'b0;
        end
      end else begin
        rx_cnt_ff <= rx_cnt_ff + 6'h01;
        if (rx_rise && (rx_cnt_ff >= 6'(CELL_CYC / 2 - RX_TOL_CYC))) begin
          rx_hit_ff <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Diagnostic and status flags, set wins over clear on read
  wire rebuild_self = rebuild_done_evt && rebuild_by_us;
  wire token_other  = token_seen_evt && !token_own_evt;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_activity_flag      <= 1'b0;
      token_seen_flag       <= 1'b0;
      self_rebuild_flag     <= 1'b0;
      topology_rebuild_flag <= 1'b0;
      irq_ff                <= 1'b0;
    end else begin
      rx_activity_flag      <= rx_nrz_rise || (rx_activity_flag && !diag_read);
      token_seen_flag       <= token_other || (token_seen_flag && !diag_read);
      self_rebuild_flag     <= rebuild_self || (self_rebuild_flag && !diag_read);
      topology_rebuild_flag <= rebuild_done_evt || (topology_rebuild_flag && !status_read);
      irq_ff                <= rebuild_done_evt || (topology_rebuild_flag && !status_read);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Activity LEDs
  nidl_oneshot #(.LEN(TX_LED_LEN)) u_tx_led (
    .clk      (clk),
    .rst_n    (rst_n),
    .trig     (tx_send),
    .led_n_ff (transmit_led_n)
  );

  nidl_oneshot #(.LEN(BUS_LED_LEN)) u_bus_led (
    .clk      (clk),
    .rst_n    (rst_n),
    .trig     (host_access),
    .led_n_ff (bus_access_led_n)
  );
endmodule
`default_nettype wire

/* nidl_chk.sv */
/* Port checker for nidl_top.
   Assumes it is bound into nidl_top and sees only its ports. */
`timescale 1ns/100ps
`default_nettype none
module nidl_chk import nidl_pkg::*; #(
  parameter int unsigned TX_LED_LEN  = 50,
  parameter int unsigned BUS_LED_LEN = 100
) (
  // Clock, reset and identity
  input wire logic       clk, rst_n, id_wr, run_enable_ff,
  input wire logic [7:0] id_switch, id_wdata, node_id_ff, dest_id,
  // Address match and transmit
  input wire logic       dest_valid, frame_for_us_ff, frame_broadcast_ff,
  input wire logic       tx_bit_ready_ff, tx_bit, transmit_disable_bit,
  input wire logic       line_pulse_a_n, line_pulse_b_n,
  // Events, flags and LEDs
  input wire logic       token_seen_evt, token_own_evt, token_seen_flag,
  input wire logic       rebuild_done_evt, rebuild_by_us, self_rebuild_flag,
  input wire logic       irq_ff, diag_read, host_access, bus_access_led_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_id_load: assert property ($rose(rst_n) |=> node_id_ff == $past(id_switch))
    else $error("identity not loaded");
  a_run_needs_id: assert property (run_enable_ff |-> node_id_ff != 8'h00)
    else $error("running with zero identity");
  a_id_write: assert property (id_wr && id_wdata != 8'h00 |=> node_id_ff == $past(id_wdata) && run_enable_ff)
    else $error("identity write lost");
  a_zero_ignored: assert property (id_wr && id_wdata == 8'h00 |=> $stable(node_id_ff) && $stable(run_enable_ff))
    else $error("zero write took effect");
  a_dest_match: assert property (dest_valid |=> frame_broadcast_ff == ($past(dest_id) == 8'h00))
    else $error("broadcast match wrong");
  a_one_pulses: assert property (tx_bit_ready_ff && $past(tx_bit) |->
    (!line_pulse_a_n && line_pulse_b_n)[*8] ##3 (line_pulse_a_n && !line_pulse_b_n)[*8])
    else $error("one bit pulses wrong");
  a_zero_quiet: assert property (tx_bit_ready_ff && !$past(tx_bit) |-> (line_pulse_a_n && line_pulse_b_n)[*8])
    else $error("zero bit pulsed");
  a_tx_blocked: assert property (transmit_disable_bit || !run_enable_ff |=> !tx_bit_ready_ff)
    else $error("bit taken while blocked");
  a_token_seen: assert property (token_seen_evt && !token_own_evt |=> token_seen_flag)
    else $error("token flag not set");
  a_self_flag: assert property (rebuild_done_evt && rebuild_by_us |=> self_rebuild_flag)
    else $error("self rebuild flag not set");
  a_rebuild_irq: assert property (rebuild_done_evt |-> ##[1:2] irq_ff)
    else $error("no rebuild interrupt");
  a_diag_clear: assert property (diag_read && !token_seen_evt && !rebuild_done_evt
    |=> !token_seen_flag && !self_rebuild_flag)
    else $error("flags not cleared");
  a_bus_led: assert property (host_access |=> ##1 (!bus_access_led_n)[*8])
    else $error("bus led not lit");
  c_tx_one: cover property (tx_bit_ready_ff && $past(tx_bit));
  c_bcast: cover property (dest_valid && dest_id == 8'h00);
  c_id_write: cover property (id_wr && id_wdata != 8'h00);
endmodule
bind nidl_top nidl_chk #(.TX_LED_LEN(TX_LED_LEN), .BUS_LED_LEN(BUS_LED_LEN)) i_chk (.*);
`default_nettype wire

/* nidl_line_model.sv */
/* Line driver and transformer model at the far side.
   Assumes 40 clock cycles per bit cell. */
`timescale 1ns/100ps
`default_nettype none
module nidl_line_model (
  // Clock and line pulses from the block
  input  wire logic clk,
  input  wire logic line_pulse_a_n,
  input  wire logic line_pulse_b_n,
  // Dipulse count and receive pulse
  output var  int   dipulse_cnt,
  output var  logic line_receive_input
);
  logic a_seen = 1'b0;  // Pulse a done, b awaited
  initial dipulse_cnt = 0;
  initial line_receive_input = 1'b0;
  // A dipulse is pulse a then pulse b
  always @(posedge clk) begin
    if (!line_pulse_a_n) a_seen <= 1'b1;
    else if (!line_pulse_b_n && a_seen) begin
      dipulse_cnt <= dipulse_cnt + 1;
      a_seen <= 1'b0;
    end
  end
  // One positive pulse per one bit, LSB first, skewed by jit
  task automatic send(input logic [7:0] bits, input int jit);
    int o;
    logic p;  // Line level for this cycle, driven once
    for (int t = 0; t < 330; t++) begin
      @(posedge clk);
      p = 1'b0;
      for (int k = 0; k < 8; k++) begin
        o = 40 * k + 8 + ((k % 2) ? jit : -jit);
        if (bits[k] && t >= o && t < o + 3) p = 1'b1;
      end
      line_receive_input <= p;
    end
  endtask
endmodule
`default_nettype wire

/* tb.sv */
/* Self-checking bench for nidl_top.
   Assumes nidl_pkg, nidl_chk and the line model are compiled first. */
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, s) begin check_count++; if ((s) !== (e)) begin n_errors++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, s); end end
module tb import nidl_pkg::*;;
  logic clk, rst_n, id_wr, dest_valid, tx_bit_valid, tx_bit, transmit_disable_bit;
  logic token_seen_evt, token_own_evt, rebuild_done_evt, rebuild_by_us;
  logic diag_read, status_read, host_access, line_receive_input;
  logic [7:0] id_switch, id_wdata, dest_id, node_id_ff, v;
  logic run_enable_ff, frame_for_us_ff, frame_broadcast_ff, tx_bit_ready_ff;
  logic line_pulse_a_n, line_pulse_b_n, rx_nrz_ff, rx_bit_strobe_ff, irq_ff;
  logic rx_activity_flag, token_seen_flag, self_rebuild_flag, topology_rebuild_flag;
  logic transmit_led_n, bus_access_led_n, lk, bt;
  logic [31:0] seed = 32'h2681;
  logic q[$], g[$];  // Expected and seen NRZ bits
  int n_errors = 0, check_count = 0, dipulse_cnt, d0, w;
  nidl_top #(.TX_LED_LEN(50), .BUS_LED_LEN(100)) i_dut (.*);
  nidl_line_model i_line (.*);
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  // Collect each recovered bit
  always @(negedge clk) if (rx_bit_strobe_ff === 1'b1) g.push_back(rx_nrz_ff);
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic cyc(input int n); repeat (n) @(negedge clk); endtask
  task automatic pulse(ref logic s); s = 1'b1; cyc(1); s = 1'b0; endtask
  task automatic rst(input logic [7:0] sw); id_switch = sw; rst_n = 0; cyc(2); rst_n = 1; cyc(2); endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #300000;
    n_errors++;
    end_of_test();
  end
  ////////////////////////////////////////
  initial begin
    {rst_n, id_wr, dest_valid, tx_bit_valid, tx_bit, transmit_disable_bit} = '0;
    {token_seen_evt, token_own_evt, rebuild_done_evt, rebuild_by_us} = '0;
    {diag_read, status_read, host_access, id_wdata, dest_id, id_switch} = '0;
    rst(8'h00);
    `CHK("run", 1'b0, run_enable_ff)
    pulse(id_wr);
    `CHK("run", 1'b0, run_enable_ff)
    id_wdata = 8'(xs()) | 8'h01;
    cyc(1);
    pulse(id_wr);
    `CHK("id", id_wdata, node_id_ff)
    `CHK("run", 1'b1, run_enable_ff)
    // Valid switch settings, both ends of the range
    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? 8'h01 : (i == 1) ? 8'hff : 8'(xs()) | 8'h01;
      rst(v);
      `CHK("id", v, node_id_ff)
      `CHK("run", 1'b1, run_enable_ff)
    end
    for (int i = 0; i < 3; i++) begin
      dest_id = (i == 0) ? 8'h00 : (i == 1) ? v : ~v;
      pulse(dest_valid);
      `CHK("bcast", dest_id == 8'h00, frame_broadcast_ff)
      `CHK("for_us", (i < 2) || (dest_id == 8'h00), frame_for_us_ff)
      cyc(1);
    end
    $display("test identity done");
    v = 8'(xs()) | 8'h80;
    d0 = dipulse_cnt;
    tx_bit_valid = 1;
    for (int k = 0; k < 8; k++) begin
      tx_bit = v[k];
      for (w = 0; tx_bit_ready_ff !== 1'b1 && w < 60; w++) cyc(1);
      `CHK("ready", 1'b1, tx_bit_ready_ff)
      cyc(1);
    end
    tx_bit_valid = 0;
    cyc(20);
    `CHK("dipulses", d0 + $countones(v), dipulse_cnt)
    `CHK("txled", 1'b0, transmit_led_n)
    cyc(60);
    `CHK("txled", 1'b1, transmit_led_n)
    $display("test transmit done");
    // Transmitter off while frames arrive
    d0 = dipulse_cnt;
    {transmit_disable_bit, tx_bit, tx_bit_valid} = 3'h7;
    for (int f = 0; f < 2; f++) begin
      v = 8'(xs()) | 8'h01;
      lk = 0;
      for (int k = 0; k < 9; k++) begin
        bt = (k < 8) && v[k];
        if (lk || bt) q.push_back(bt);
        lk = bt;
      end
      i_line.send(v, int'(xs() % 5));
      cyc(50);
    end
    `CHK("nbits", q.size(), g.size())
    foreach (q[i]) `CHK("nrz", q[i], g[i])
    `CHK("act", 1'b1, rx_activity_flag)
    `CHK("dipulses", d0, dipulse_cnt)
    {transmit_disable_bit, tx_bit_valid} = '0;
    $display("test receive done");
    // Own token together with the seen event must not set the flag
    token_own_evt = 1'b1;
    pulse(token_seen_evt);
    token_own_evt = 1'b0;
    `CHK("tok", 1'b0, token_seen_flag)
    cyc(1);
    pulse(token_seen_evt);
    `CHK("tok", 1'b1, token_seen_flag)
    pulse(diag_read);
    `CHK("tok", 1'b0, token_seen_flag)
    `CHK("act", 1'b0, rx_activity_flag)
    rebuild_by_us = 1;
    pulse(rebuild_done_evt);
    rebuild_by_us = 0;
    cyc(1);
    `CHK("irq", 1'b1, irq_ff)
    pulse(status_read);
    cyc(1);
    `CHK("irq", 1'b0, irq_ff)
    `CHK("self", 1'b1, self_rebuild_flag)
    pulse(diag_read);
    pulse(rebuild_done_evt);
    cyc(1);
    `CHK("self", 1'b0, self_rebuild_flag)
    `CHK("topo", 1'b1, topology_rebuild_flag)
    pulse(host_access);
    cyc(95);
    `CHK("busled", 1'b0, bus_access_led_n)
    cyc(12);
    `CHK("busled", 1'b1, bus_access_led_n)
    $display("test flags done");
    end_of_test();
  end
endmodule
`default_nettype wire
